// *** core/dlasc_params.svh ***
/*
 * Constants of the output-load and input-sequencing control block:
 * register indexes, field positions, reset values and codes.
 * Assumes it is included by bare name from the package and the modules.
 */
// ==========================================================================
// Notes on behaviour
// - Sync-load output copies data register to latch on a load event.
// - External load pin rising edge and internal load pulse act identically.
// - Sync-load output: data write changes only the data register.
// - Async output: write goes straight to latch; load events ignored.
// - Gain bit one selects buffer gain two, zero selects gain one.
// - Config register: load enables bits 15..8, gains bits 7..0, reset zero.
// - Writing the load code makes the internal load pulse for sync outputs.
// - Any other load-register value makes no pulse and changes nothing.
// - Load register clears after the pulse and on reset.
// - Trigger disabled: every sequencing control write starts a sequence.
// - Trigger enabled: control write records the range only.
// - Single-pass converts start to end once, then idles.
// - Repeat mode returns to start after end and continues.
// - Repeat stops only on single-pass rewrite or trigger enable.
// - Trigger enabled forces the repeat bit to zero.
// - Repeat bit 15, start bits 11..8, end bits 7..4, reset 0x0000.
// - Channel codes 0..8; code 8 is the temperature sensor.
// - External trigger accepts any start 0..8 with end not below it.
// - Trigger enabled: convert pin rising edge starts one pass.
// - Result registers update when the end channel finishes.
// ==========================================================================
`ifndef DLASC_PARAMS_SVH
`define DLASC_PARAMS_SVH

// Register indexes on the serial port
`define DLASC_IDX_STATCFG 5'h0A
`define DLASC_IDX_OUTCFG 5'h09
`define DLASC_IDX_SEQCTRL 5'h0B
`define DLASC_IDX_LOAD 5'h0D
`define DLASC_IDX_DATA0 5'h10
`define DLASC_IDX_DATA7 5'h17

// Field positions
`define DLASC_OUTCFG_SYNC_HI 15
`define DLASC_OUTCFG_SYNC_LO 8
`define DLASC_OUTCFG_GAIN_HI 7
`define DLASC_OUTCFG_GAIN_LO 0
`define DLASC_SEQ_REPEAT 15
`define DLASC_SEQ_FIRST_HI 11
`define DLASC_SEQ_FIRST_LO 8
`define DLASC_SEQ_LAST_HI 7
`define DLASC_SEQ_LAST_LO 4
`define DLASC_STAT_EXTTRIG 5
`define DLASC_CMD_READ 15
`define DLASC_CMD_IDX_HI 4

// Values
`define DLASC_LOAD_CODE 16'hBB00
`define DLASC_ZERO16 16'h0000
`define DLASC_CHAN_MAX 4'h8
`define DLASC_FRAME_BITS 6'h20
`define DLASC_WORD_BITS 6'h10

`endif

// *** core/dlasc_pkg.sv ***
/*
 * Types shared by the control block's modules.
 * Assumes dlasc_params.svh is on the include path.
 */
`include "dlasc_params.svh"

package dlasc_pkg;
    // One register write from the serial port
    typedef struct packed {
        logic [4:0] idx;
        logic [15:0] data;
    } dlasc_wr_t;

    // Sequencing control fields
    typedef struct packed {
        logic repeat_mode;
        logic [3:0] first_channel_index;
        logic [3:0] last_channel_index;
    } dlasc_seq_cfg_t;

    typedef enum logic [1:0] {
        DLASC_SEQ_IDLE,
        DLASC_SEQ_START,
        DLASC_SEQ_WAIT
    } dlasc_seq_state_t;
endpackage

// *** core/dlasc_spi_slave.sv ***
/*
 * Serial register port: 32-bit frames, command word then data word,
 * mode 0, MSB first. Command bit 15 set means read, bits 4..0 index.
 * Assumes the serial clock is far slower than the core clock.
 */
`include "dlasc_params.svh"

module dlasc_spi_slave
    import dlasc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    input wire logic [15:0] i_rd_data,
    output logic [4:0] o_rd_idx,
    output logic o_wr_valid,
    output dlasc_wr_t o_wr,
    output logic o_miso,
    output logic o_miso_oe
);
    // ======================================================================
    // Pin synchronisers
    logic [1:0] sclk_s_q;
    logic [1:0] ss_s_q;
    logic [1:0] mosi_s_q;
    logic sclk_d1_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_s_q <= 2'h0;
            ss_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_s_q <= {sclk_s_q[0], i_sclk};
            ss_s_q <= {ss_s_q[0], i_ss_n};
            mosi_s_q <= {mosi_s_q[0], i_mosi};
            sclk_d1_q <= sclk_s_q[1];
        end
    end

    logic active;
    logic rise;
    logic fall;
    assign active = !ss_s_q[1];
    assign rise = active && sclk_s_q[1] && !sclk_d1_q;
    assign fall = active && !sclk_s_q[1] && sclk_d1_q;

    // ======================================================================
    // Receive shift and bit count
    logic [5:0] cnt_q;
    logic [15:0] shift_q;
    logic [15:0] cmd_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 6'h00;
            shift_q <= 16'h0000;
            cmd_q <= 16'h0000;
        end else if (!active) begin
            cnt_q <= 6'h00;
        end else if (rise && cnt_q != `DLASC_FRAME_BITS) begin
            cnt_q <= cnt_q + 6'h01;
            shift_q <= {shift_q[14:0], mosi_s_q[1]};
            if (cnt_q == `DLASC_WORD_BITS - 6'h01) begin
                cmd_q <= {shift_q[14:0], mosi_s_q[1]};
            end
        end
    end

    assign o_rd_idx = cmd_q[`DLASC_CMD_IDX_HI:0];

    // Write strobe after the last data bit; reads ignore the data word
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_valid <= 1'b0;
            o_wr <= '0;
        end else begin
            o_wr_valid <= rise && cnt_q == `DLASC_FRAME_BITS - 6'h01 && !cmd_q[`DLASC_CMD_READ];
            o_wr <= '{idx: cmd_q[`DLASC_CMD_IDX_HI:0], data: {shift_q[14:0], mosi_s_q[1]}};
        end
    end

    // ======================================================================
    // Transmit: read word loaded once the command is in, shifted on falls
    logic [15:0] tx_q;
    logic load_tx_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_q <= 16'h0000;
            load_tx_q <= 1'b0;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            load_tx_q <= rise && cnt_q == `DLASC_WORD_BITS - 6'h01;
            o_miso_oe <= active;
            if (load_tx_q) begin
                tx_q <= i_rd_data; // index is stable from this cycle on
            end else if (fall && cnt_q > `DLASC_WORD_BITS) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
            if (load_tx_q) begin
                o_miso <= i_rd_data[15];
            end else if (fall && cnt_q > `DLASC_WORD_BITS) begin
                o_miso <= tx_q[14];
            end
        end
    end
endmodule

// *** core/dlasc_seq.sv ***
/*
 * Input multiplexer sequencer: walks channels from first to last index,
 * once or repeatedly. Assumes the converter returns one done pulse per
 * conversion start, on the same clock.
 */
`include "dlasc_params.svh"

module dlasc_seq
    import dlasc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire dlasc_seq_cfg_t i_cfg,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_conv_done,
    output logic [3:0] o_mux_channel,
    output logic o_conv_start,
    output logic o_result_update,
    output logic o_busy
);
    dlasc_seq_state_t state_q;

    // ======================================================================
    // Channel walk; a new start restarts the pass from the first index
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= DLASC_SEQ_IDLE;
            o_mux_channel <= 4'h0;
            o_conv_start <= 1'b0;
            o_result_update <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            o_result_update <= 1'b0;
            if (i_abort) begin
                state_q <= DLASC_SEQ_IDLE;
            end else if (i_start) begin
                o_mux_channel <= i_cfg.first_channel_index;
                state_q <= DLASC_SEQ_START;
            end else begin
                unique case (state_q)
                    DLASC_SEQ_IDLE: begin
                    end
                    DLASC_SEQ_START: begin
                        o_conv_start <= 1'b1;
                        state_q <= DLASC_SEQ_WAIT;
                    end
                    DLASC_SEQ_WAIT: begin
                        if (i_conv_done) begin
                            // Stop at the last index; code 8 is the sensor
                            if (o_mux_channel == i_cfg.last_channel_index ||
                                    o_mux_channel == `DLASC_CHAN_MAX) begin
                                o_result_update <= 1'b1;
                                if (i_cfg.repeat_mode) begin
                                    o_mux_channel <= i_cfg.first_channel_index;
                                    state_q <= DLASC_SEQ_START;
                                end else begin
                                    state_q <= DLASC_SEQ_IDLE;
                                end
                            end else begin
                                o_mux_channel <= o_mux_channel + 4'h1;
                                state_q <= DLASC_SEQ_START;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign o_busy = state_q != DLASC_SEQ_IDLE;
endmodule

// *** core/dlasc_top.sv ***
/*
 * Output load/gain control and input sequencing control, with the serial
 * register port. Holds eight output data registers and their latches.
 * Assumes the load and convert pins are asynchronous and the converter
 * answers each start with one done pulse on i_ref_clk.
 */
`include "dlasc_params.svh"

module dlasc_top
    import dlasc_pkg::*;
#(
    parameter int unsigned NUM_OUT = 8,
    parameter int unsigned DATA_W = 12
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sclk,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    input wire logic i_external_load_pin,
    input wire logic i_convert_pin,
    input wire logic i_conv_done,
    output logic o_miso,
    output logic o_miso_oe,
    output logic [NUM_OUT-1:0][DATA_W-1:0] o_out_value,
    output logic [NUM_OUT-1:0] o_output_gain_double,
    output logic [3:0] o_mux_channel,
    output logic o_conv_start,
    output logic o_result_update
);
    // ======================================================================
    // Serial port
    logic wr_valid;
    dlasc_wr_t wr;
    logic [4:0] rd_idx;
    logic [15:0] rd_data;

    dlasc_spi_slave u_spi (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_sclk(i_sclk),
        .i_ss_n(i_ss_n),
        .i_mosi(i_mosi),
        .i_rd_data(rd_data),
        .o_rd_idx(rd_idx),
        .o_wr_valid(wr_valid),
        .o_wr(wr),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe)
    );

    // Strobe is an argument: a continuous assignment only re-evaluates on its operands
    function automatic logic hit(input logic valid, input logic [4:0] idx, input logic [4:0] want);
        hit = valid && idx == want;
    endfunction

    // Data register index to output number, or no match
    function automatic logic data_hit(input logic [4:0] idx, input int unsigned n);
        data_hit = idx >= `DLASC_IDX_DATA0 && idx <= `DLASC_IDX_DATA7 &&
                   idx - `DLASC_IDX_DATA0 == 5'(n);
    endfunction

    // ======================================================================
    // Pin synchronisers and rising-edge detect
    logic [2:0] eld_s_q;
    logic [2:0] cnv_s_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            eld_s_q <= 3'h0;
            cnv_s_q <= 3'h0;
        end else begin
            eld_s_q <= {eld_s_q[1:0], i_external_load_pin};
            cnv_s_q <= {cnv_s_q[1:0], i_convert_pin};
        end
    end

    logic ext_load_edge;
    logic ext_conv_edge;
    assign ext_load_edge = eld_s_q[1] && !eld_s_q[2];
    assign ext_conv_edge = cnv_s_q[1] && !cnv_s_q[2];

    // ======================================================================
    // Output configuration: load enables high byte, gains low byte
    logic [15:0] outcfg_q;
    logic [NUM_OUT-1:0] sync_load_enable;
    assign sync_load_enable = outcfg_q[`DLASC_OUTCFG_SYNC_HI:`DLASC_OUTCFG_SYNC_LO];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            outcfg_q <= `DLASC_ZERO16;
        end else if (hit(wr_valid, wr.idx, `DLASC_IDX_OUTCFG)) begin
            outcfg_q <= wr.data;
        end
    end

    // Gain select follows its bit: one means gain two
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_output_gain_double <= '0;
        end else begin
            o_output_gain_double <= outcfg_q[`DLASC_OUTCFG_GAIN_HI:`DLASC_OUTCFG_GAIN_LO];
        end
    end

    // ======================================================================
    // Load register; the code raises a one-cycle pulse, then clears
    logic [15:0] load_q;
    logic internal_load_pulse;
    logic load_event;
    assign internal_load_pulse = load_q == `DLASC_LOAD_CODE;
    assign load_event = internal_load_pulse || ext_load_edge;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            load_q <= `DLASC_ZERO16;
        end else if (hit(wr_valid, wr.idx, `DLASC_IDX_LOAD)) begin
            load_q <= wr.data;
        end else if (internal_load_pulse) begin
            load_q <= `DLASC_ZERO16;
        end
    end

    // ======================================================================
    // Data registers and latches; the latch drives the output directly
    logic [NUM_OUT-1:0][DATA_W-1:0] data_q;
    for (genvar n = 0; n < NUM_OUT; n++) begin : g_out
        always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                data_q[n] <= '0;
            end else if (wr_valid && data_hit(wr.idx, n)) begin
                data_q[n] <= wr.data[DATA_W-1:0];
            end
        end

        // A write in the same cycle as a load event: the event takes the
        // old data register, the new word waits for the next event
        always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                o_out_value[n] <= '0;
            end else if (!sync_load_enable[n]) begin
                if (wr_valid && data_hit(wr.idx, n)) begin
                    o_out_value[n] <= wr.data[DATA_W-1:0];
                end
            end else if (load_event) begin
                o_out_value[n] <= data_q[n];
            end
        end
    end

    // ======================================================================
    // Status/config: only the external trigger enable lives here
    logic external_trigger_enable_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            external_trigger_enable_q <= 1'b0;
        end else if (hit(wr_valid, wr.idx, `DLASC_IDX_STATCFG)) begin
            external_trigger_enable_q <= wr.data[`DLASC_STAT_EXTTRIG];
        end
    end

    // ======================================================================
    // Sequencing control register
    dlasc_seq_cfg_t seq_cfg_q;
    logic seq_wr;
    logic ext_trig_rise;
    assign seq_wr = hit(wr_valid, wr.idx, `DLASC_IDX_SEQCTRL);
    assign ext_trig_rise = hit(wr_valid, wr.idx, `DLASC_IDX_STATCFG) && wr.data[`DLASC_STAT_EXTTRIG] &&
                           !external_trigger_enable_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_cfg_q <= '0;
        end else if (seq_wr) begin
            seq_cfg_q.repeat_mode <= wr.data[`DLASC_SEQ_REPEAT] && !external_trigger_enable_q;
            seq_cfg_q.first_channel_index <= wr.data[`DLASC_SEQ_FIRST_HI:`DLASC_SEQ_FIRST_LO];
            seq_cfg_q.last_channel_index <= wr.data[`DLASC_SEQ_LAST_HI:`DLASC_SEQ_LAST_LO];
        end else if (external_trigger_enable_q || ext_trig_rise) begin
            seq_cfg_q.repeat_mode <= 1'b0;
        end
    end

    // Start: a control write on internal trigger, or a pin edge on external
    logic seq_start;
    logic seq_abort;
    assign seq_start = (seq_wr && !external_trigger_enable_q) ||
                       (ext_conv_edge && external_trigger_enable_q);
    assign seq_abort = ext_trig_rise;

    dlasc_seq u_seq (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_cfg(seq_cfg_q),
        .i_start(seq_start),
        .i_abort(seq_abort),
        .i_conv_done(i_conv_done),
        .o_mux_channel(o_mux_channel),
        .o_conv_start(o_conv_start),
        .o_result_update(o_result_update),
        .o_busy()
    );

    // ======================================================================
    // Read mux; data registers read back through their latches
    always_comb begin
        rd_data = `DLASC_ZERO16;
        unique case (rd_idx)
            `DLASC_IDX_OUTCFG: rd_data = outcfg_q;
            `DLASC_IDX_LOAD: rd_data = load_q;
            `DLASC_IDX_STATCFG: rd_data[`DLASC_STAT_EXTTRIG] = external_trigger_enable_q;
            `DLASC_IDX_SEQCTRL: begin
                rd_data[`DLASC_SEQ_REPEAT] = seq_cfg_q.repeat_mode;
                rd_data[`DLASC_SEQ_FIRST_HI:`DLASC_SEQ_FIRST_LO] = seq_cfg_q.first_channel_index;
                rd_data[`DLASC_SEQ_LAST_HI:`DLASC_SEQ_LAST_LO] = seq_cfg_q.last_channel_index;
            end
            default: begin
                for (int n = 0; n < NUM_OUT; n++) begin
                    if (data_hit(rd_idx, n)) begin
                        rd_data[DATA_W-1:0] = o_out_value[n];
                    end
                end
            end
        endcase
    end
endmodule

// *** testbench/dlasc_top_assertions.sv ***
/* Port checker for the control block top.
   Assumes one clock domain and an active-low asynchronous reset. */
module dlasc_top_assertions #(
    parameter int unsigned NUM_OUT = 8,
    parameter int unsigned DATA_W = 12
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_conv_done,
    input wire logic [NUM_OUT-1:0][DATA_W-1:0] o_out_value,
    input wire logic [NUM_OUT-1:0] o_output_gain_double,
    input wire logic [3:0] o_mux_channel,
    input wire logic o_conv_start,
    input wire logic o_result_update
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Sequencer and output checks
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_chan_in_range: assert property (o_mux_channel <= 4'h8)
        else $error("mux channel above sensor code");
    a_reset_clears: assert property ($rose(i_rst_n) |-> o_out_value == '0 && o_output_gain_double == '0)
        else $error("outputs not clear after reset");
    a_reset_mux_zero: assert property ($rose(i_rst_n) |-> o_mux_channel == 4'h0)
        else $error("mux not zero after reset");
    a_update_after_done: assert property (o_result_update |-> $past(i_conv_done))
        else $error("update without converter done");
    a_update_one_cycle: assert property (o_result_update |=> !o_result_update)
        else $error("update longer than one cycle");
    a_start_one_cycle: assert property (o_conv_start |=> !o_conv_start)
        else $error("start longer than one cycle");
    a_mux_steady_start: assert property (o_conv_start |-> $stable(o_mux_channel))
        else $error("mux moved at conversion start");
    a_done_not_start: assert property (i_conv_done |-> !o_conv_start)
        else $error("start while conversion finishing");
    a_update_not_start: assert property (o_result_update |-> !o_conv_start)
        else $error("start together with update");
endmodule

bind dlasc_top dlasc_top_assertions #(.NUM_OUT(NUM_OUT), .DATA_W(DATA_W)) u_checker (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_conv_done(i_conv_done),
    .o_out_value(o_out_value),
    .o_output_gain_double(o_output_gain_double),
    .o_mux_channel(o_mux_channel),
    .o_conv_start(o_conv_start),
    .o_result_update(o_result_update)
);

// *** testbench/dlasc_host_model.sv ***
/* Far side model: serial host and converter answer.
   Assumes the serial half period may be six core clocks. */
module dlasc_host_model (
    input wire logic i_ref_clk,
    input wire logic i_conv_start,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_ss_n,
    output logic o_mosi,
    output logic o_conv_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic slow = 1'b0;

    initial begin
        o_sclk = 1'b0;
        o_ss_n = 1'b1;
        o_mosi = 1'b0;
        o_conv_done = 1'b0;
    end

    // ==========
    // Converter: one done per start, prompt and slow in turn
    always @(posedge i_ref_clk) begin
        if (i_conv_start) begin
            repeat (slow ? 7 : 2) @(posedge i_ref_clk);
            o_conv_done <= 1'b1;
            slow <= !slow;
            @(posedge i_ref_clk);
            o_conv_done <= 1'b0;
        end
    end

    // ==========
    // Mode 0 frame, MSB first; clock stands still between frames
    task automatic xfer(input logic [31:0] frame, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge i_ref_clk);
        o_ss_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_mosi <= frame[i];
            repeat (6) @(posedge i_ref_clk);
            o_sclk <= 1'b1;
            if (i < 16) begin
                rd[i] = i_miso; // Taken at the rise, before it can move
            end
            repeat (6) @(posedge i_ref_clk);
            o_sclk <= 1'b0;
        end
        repeat (6) @(posedge i_ref_clk);
        o_ss_n <= 1'b1;
        o_mosi <= !frame[0]; // Released line must not look valid
        repeat (8) @(posedge i_ref_clk);
    endtask
endmodule

// *** testbench/test_dlasc_top.sv ***
/* Self-checking bench for the control block.
   Assumes the core files and the host model are compiled first. */
`include "dlasc_params.svh"

module test_dlasc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, eload, cpin, sclk, ss_n, mosi, done, miso, start, upd, free;
    logic [7:0][11:0] outv;
    logic [7:0] gain;
    logic [3:0] mux;
    logic [3:0] nconv = 4'h0;
    logic [11:0] u, v, w;
    logic [15:0] r;
    logic [3:0] chan_q[$];
    logic [3:0] upd_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int seed = 95046;

    dlasc_top uut (
        .i_ref_clk(clk),
        .i_rst_n(rst_n),
        .i_sclk(sclk),
        .i_ss_n(ss_n),
        .i_mosi(mosi),
        .i_external_load_pin(eload),
        .i_convert_pin(cpin),
        .i_conv_done(done),
        .o_miso(miso),
        .o_miso_oe(),
        .o_out_value(outv),
        .o_output_gain_double(gain),
        .o_mux_channel(mux),
        .o_conv_start(start),
        .o_result_update(upd)
    );

    dlasc_host_model u_host (
        .i_ref_clk(clk),
        .i_conv_start(start),
        .i_miso(miso),
        .o_sclk(sclk),
        .o_ss_n(ss_n),
        .o_mosi(mosi),
        .o_conv_done(done)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========
    // Compare and report
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_chan(input logic [3:0] got, input logic [3:0] exp);
        cmp_val({12'h000, got}, {12'h000, exp});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========
    // Register and pin helpers
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        u_host.xfer({11'h000, idx, d}, r);
    endtask

    task automatic rd_chk(input logic [4:0] idx, input logic [15:0] e);
        u_host.xfer({11'h400, idx, 16'h0000}, r);
        cmp_val(r, e);
    endtask

    task automatic pulse(input logic conv);
        cpin <= conv;
        eload <= !conv;
        repeat (4) @(posedge clk);
        cpin <= 1'b0;
        eload <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    task automatic expect_pass(input int first, input int last, input int passes);
        for (int p = 0; p < passes; p++) begin
            for (int c = first; c <= last; c++) begin
                chan_q.push_back(4'(c));
            end
            upd_q.push_back(4'(last - first + 1));
        end
    endtask

    // Bounded wait; a hang ends the run as a failure
    task automatic wait_drain();
        for (int i = 0; i < 3000 && (chan_q.size() + upd_q.size()) > 0; i++) begin
            @(posedge clk);
        end
        if ((chan_q.size() + upd_q.size()) > 0) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // Watcher: while free is low, every start and every update takes the oldest note
    always @(posedge clk) begin
        if (free) begin
            nconv = 4'h0;
        end
        if (start === 1'b1 && !free) begin
            cmp_chan(mux, chan_q.size() > 0 ? chan_q.pop_front() : 4'hF);
        end
        if (start === 1'b1) begin
            nconv = nconv + 4'h1;
        end
        if (upd === 1'b1 && !free) begin
            cmp_chan(nconv, upd_q.size() > 0 ? upd_q.pop_front() : 4'hF);
        end
        if (upd === 1'b1) begin
            nconv = 4'h0;
        end
    end

    // ==========
    // Main sequence
    initial begin
        rst_n = 1'b0;
        eload = 1'b0;
        cpin = 1'b0;
        free = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`DLASC_IDX_OUTCFG, 16'h0000);
        rd_chk(`DLASC_IDX_SEQCTRL, 16'h0000);
        rd_chk(`DLASC_IDX_LOAD, 16'h0000);
        wr(5'h1F, 16'hFFFF);
        rd_chk(5'h1F, 16'h0000);
        wr(`DLASC_IDX_OUTCFG, 16'h00A5);
        cmp_val({8'h00, gain}, 16'h00A5);
        u = 12'($random(seed)) | 12'h001;
        wr(`DLASC_IDX_DATA0 + 5'h02, {4'h0, u});
        cmp_val({4'h0, outv[2]}, {4'h0, u});
        wr(`DLASC_IDX_OUTCFG, 16'h04A5);
        wr(`DLASC_IDX_DATA0 + 5'h02, {4'h0, ~u});
        cmp_val({4'h0, outv[2]}, {4'h0, u});
        wr(`DLASC_IDX_OUTCFG, 16'hF0A5);
        rd_chk(`DLASC_IDX_OUTCFG, 16'hF0A5);
        v = 12'($random(seed)) | 12'h001;
        wr(`DLASC_IDX_DATA0 + 5'h05, {4'h0, v});
        cmp_val({4'h0, outv[5]}, 16'h0000);
        wr(`DLASC_IDX_LOAD, 16'h1234);
        cmp_val({4'h0, outv[5]}, 16'h0000);
        rd_chk(`DLASC_IDX_LOAD, 16'h1234);
        wr(`DLASC_IDX_LOAD, 16'hBB00);
        cmp_val({4'h0, outv[5]}, {4'h0, v});
        rd_chk(`DLASC_IDX_LOAD, 16'h0000);
        w = 12'($random(seed)) | 12'h001;
        wr(`DLASC_IDX_DATA0 + 5'h06, {4'h0, w});
        pulse(1'b0);
        cmp_val({4'h0, outv[6]}, {4'h0, w});
        cmp_val({4'h0, outv[2]}, {4'h0, u});
        expect_pass(0, 3, 1);
        wr(`DLASC_IDX_SEQCTRL, 16'h0030);
        wait_drain();
        expect_pass(0, 2, 3);
        wr(`DLASC_IDX_SEQCTRL, 16'h8020);
        wait_drain();
        free = 1'b1;
        wr(`DLASC_IDX_STATCFG, 16'h0020);
        repeat (20) @(posedge clk);
        free = 1'b0;
        rd_chk(`DLASC_IDX_SEQCTRL, 16'h0020);
        wr(`DLASC_IDX_SEQCTRL, 16'h8680);
        rd_chk(`DLASC_IDX_SEQCTRL, 16'h0680);
        expect_pass(6, 8, 1);
        pulse(1'b1);
        wait_drain();
        wr(`DLASC_IDX_SEQCTRL, 16'h0880);
        expect_pass(8, 8, 1);
        pulse(1'b1);
        wait_drain();
        repeat (100) @(posedge clk);
        tally_and_finish();
    end
endmodule
